// ===== core/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
// Notes on behaviour
// - Single-rate input: pad level appears on bit 0 of the core input bus.
// - Dual-edge input: bit 0 from rising capture, bit 1 from falling.
// - Dual-edge output: core bit 0 goes out at rise, bit 1 at fall.
// - Single-rate output: pad driven from bit 0 of the core output bus.
// - Bypass input routes the pad to the one net selected by route only when unregistered.
// - Core output enable passes straight through or through a register.
// - Output and enable registers run on the launch side clock.
// - Input registers run on the separate capture side clock.
// - Dual-edge capture hands the core two bits per clock cycle.
// - Normal dual-edge: each bit crosses on its own capture edge.
// - Resync dual-edge: both bits cross on the rising edge only.
// - Resync input: falling bit held half a cycle to meet rising bit.
// - Pins reusing differential resources get no dual-edge function.
// - Input, output and enable paths all meet on one pad.
// - Each register may trigger on rising or falling clock edge.
// - Output register may invert; input and output registered apart.

// Register byte offsets
`define CTRL_OFFSET      8'h00
`define STATUS_OFFSET    8'h04
`define ADDR_BITS        8

// Control field positions
`define CTRL_IN_REG      0
`define CTRL_OUT_REG     1
`define CTRL_OE_REG      2
`define CTRL_IN_NEG      3
`define CTRL_OUT_NEG     4
`define CTRL_OE_NEG      5
`define CTRL_OUT_INV     6
`define CTRL_DUAL_IN     7
`define CTRL_DUAL_OUT    8
`define CTRL_RESYNC      9
`define CTRL_DIFF_REUSE  10
`define CTRL_ROUTE_LSB   11
`define CTRL_WIDTH       13

// Control reset value
`define CTRL_RESET       13'h0000

// Status field positions
`define STAT_PAD         0
`define STAT_IN_LSB      1
`define STAT_OE          3
`define STAT_DUAL_IN     4
`define STAT_DUAL_OUT    5

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ===== core/gpio_pkg.sv
package gpio_pkg;

  // Bypass routing destinations
  typedef enum logic [1:0] {
    ROUTE_CLOCK,
    ROUTE_CONTROL,
    ROUTE_SYNTH,
    ROUTE_SERIAL
  } route_type;

  // Decoded control register
  typedef struct packed {
    route_type route;
    logic      diff_reuse;
    logic      resync;
    logic      dual_out;
    logic      dual_in;
    logic      out_inv;
    logic      oe_neg;
    logic      out_neg;
    logic      in_neg;
    logic      oe_reg;
    logic      out_reg;
    logic      in_reg;
  } ctrl_type;

  // Edge events of one sampled clock input
  typedef struct packed {
    logic rise;
    logic fall;
  } edges_type;

endpackage

// ===== core/clock_edge_sense.sv
`timescale 1ns/1ps
module clock_edge_sense (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Sampled clock level
  input  wire logic                level,
  // Edge events
  output gpio_pkg::edges_type      edges
);

  logic now_ff;
  logic prv_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      now_ff <= 1'b0;
      prv_ff <= 1'b0;
    end else begin
      now_ff <= level;
      prv_ff <= now_ff;
    end
  end

  assign edges.rise = now_ff & ~prv_ff;
  assign edges.fall = ~now_ff & prv_ff;

endmodule

// ===== core/dual_edge_gpio_io_logic.sv
`timescale 1ns/1ps
`include "gpio_map.svh"
module dual_edge_gpio_io_logic (
  // Clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   RSTN,
  // AXI4-Lite write address
  input  wire logic [`ADDR_BITS-1:0]  AWADDR,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  // AXI4-Lite write response
  output logic [1:0]                  BRESP,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  // AXI4-Lite read address
  input  wire logic [`ADDR_BITS-1:0]  ARADDR,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  // Core clock network levels
  input  wire logic                   LAUNCH_SIDE_CLOCK,
  input  wire logic                   CAPTURE_SIDE_CLOCK,
  // Core fabric side
  input  wire logic [1:0]             CORE_OUT,
  input  wire logic                   CORE_OE,
  output logic [1:0]                  CORE_IN,
  // Bypass input and its destinations
  output logic                        BYPASS_INPUT,
  output logic                        GLOBAL_CLOCK_NET,
  output logic                        GLOBAL_CONTROL_NET,
  output logic                        SYNTH_REFERENCE_INPUT,
  output logic                        SERIAL_LINK_CLOCK_INPUT,
  // Pad
  input  wire logic                   PAD_I,
  output logic                        PAD_O,
  output logic                        PAD_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`CTRL_WIDTH-1:0]   ctrl_ff;
  gpio_pkg::ctrl_type       cfg;
  gpio_pkg::edges_type      cap_edges;
  gpio_pkg::edges_type      lau_edges;

  logic                     aw_got_ff;
  logic                     w_got_ff;
  logic [`ADDR_BITS-1:0]    aw_addr_ff;
  logic [31:0]              w_data_ff;
  logic [3:0]               w_strb_ff;
  logic                     do_write;
  logic [31:0]              nxt_rdata;
  logic [1:0]               nxt_rresp;

  logic                     dual_in_ok;
  logic                     dual_out_ok;
  logic                     in_edge;
  logic                     out_edge;
  logic                     oe_edge;

  logic                     hi_cap_ff;
  logic                     lo_cap_ff;
  logic [1:0]               nxt_core_in;

  logic                     out_q_ff;
  logic                     lo_out_ff;
  logic                     oe_q_ff;
  logic                     nxt_data;
  logic                     nxt_oe;
  logic                     bypass_on;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic pick_edge(
    input gpio_pkg::edges_type e,
    input logic                neg
  );
    pick_edge = neg ? e.fall : e.rise;
  endfunction

  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock level edge detection
  clock_edge_sense u_capture_edges (
    .clk   (MCLK),
    .rst_n (RSTN),
    .level (CAPTURE_SIDE_CLOCK),
    .edges (cap_edges)
  );

  clock_edge_sense u_launch_edges (
    .clk   (MCLK),
    .rst_n (RSTN),
    .level (LAUNCH_SIDE_CLOCK),
    .edges (lau_edges)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  assign do_write = aw_got_ff & w_got_ff & ~BVALID;

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= '0;
      AWREADY    <= 1'b0;
    end else begin
      AWREADY <= ~aw_got_ff & ~AWREADY & ~BVALID;
      if (AWVALID && AWREADY) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= AWADDR;
        AWREADY    <= 1'b0;
      end else if (do_write) begin
        aw_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      w_got_ff  <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      WREADY    <= 1'b0;
    end else begin
      WREADY <= ~w_got_ff & ~WREADY & ~BVALID;
      if (WVALID && WREADY) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
        WREADY    <= 1'b0;
      end else if (do_write) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      BVALID <= 1'b0;
      BRESP  <= `RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      if (aw_addr_ff == `CTRL_OFFSET || aw_addr_ff == `STATUS_OFFSET) begin
        BRESP <= `RESP_OKAY;
      end else begin
        BRESP <= `RESP_SLVERR;
      end
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (do_write && aw_addr_ff == `CTRL_OFFSET) begin
      ctrl_ff <= `CTRL_WIDTH'(merge_strb({19'h00000, ctrl_ff}, w_data_ff,
                                         w_strb_ff));
    end
  end

  assign cfg = gpio_pkg::ctrl_type'(ctrl_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `RESP_OKAY;
    unique case (ARADDR)
      `CTRL_OFFSET: begin
        nxt_rdata[`CTRL_WIDTH-1:0] = ctrl_ff;
      end
      `STATUS_OFFSET: begin
        nxt_rdata[`STAT_PAD]              = PAD_I;
        nxt_rdata[`STAT_IN_LSB +: 2]      = CORE_IN;
        nxt_rdata[`STAT_OE]               = PAD_OE;
        nxt_rdata[`STAT_DUAL_IN]          = dual_in_ok;
        nxt_rdata[`STAT_DUAL_OUT]         = dual_out_ok;
      end
      default: begin
        nxt_rresp = `RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
    end else begin
      ARREADY <= ~RVALID & ~ARREADY;
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= nxt_rdata;
        RRESP   <= nxt_rresp;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode qualification
  assign dual_in_ok  = cfg.dual_in & ~cfg.diff_reuse;
  assign dual_out_ok = cfg.dual_out & ~cfg.diff_reuse;
  assign in_edge     = pick_edge(cap_edges, cfg.in_neg);
  assign out_edge    = pick_edge(lau_edges, cfg.out_neg);
  assign oe_edge     = pick_edge(lau_edges, cfg.oe_neg);

  ////////////////////////////////////////////////////////////////////////////
  // Input capture, on capture side clock edges
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      hi_cap_ff <= 1'b0;
      lo_cap_ff <= 1'b0;
    end else begin
      if (cap_edges.rise) begin
        hi_cap_ff <= PAD_I;
      end
      if (cap_edges.fall) begin
        lo_cap_ff <= PAD_I;
      end
    end
  end

  always_comb begin
    nxt_core_in = CORE_IN;
    if (dual_in_ok) begin
      if (cfg.resync) begin
        if (cap_edges.rise) begin
          nxt_core_in = {lo_cap_ff, hi_cap_ff};
        end
      end else begin
        if (cap_edges.rise) begin
          nxt_core_in[0] = PAD_I;
        end
        if (cap_edges.fall) begin
          nxt_core_in[1] = PAD_I;
        end
      end
    end else if (cfg.in_reg) begin
      if (in_edge) begin
        nxt_core_in = {1'b0, PAD_I};
      end
    end else begin
      nxt_core_in = {1'b0, PAD_I};
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      CORE_IN <= 2'h0;
    end else begin
      CORE_IN <= nxt_core_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bypass input routing
  assign bypass_on = ~cfg.in_reg & ~dual_in_ok;

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      BYPASS_INPUT            <= 1'b0;
      GLOBAL_CLOCK_NET        <= 1'b0;
      GLOBAL_CONTROL_NET      <= 1'b0;
      SYNTH_REFERENCE_INPUT   <= 1'b0;
      SERIAL_LINK_CLOCK_INPUT <= 1'b0;
    end else begin
      BYPASS_INPUT <= bypass_on & PAD_I;
      GLOBAL_CLOCK_NET <= bypass_on & PAD_I
                          & (cfg.route == gpio_pkg::ROUTE_CLOCK);
      GLOBAL_CONTROL_NET <= bypass_on & PAD_I
                            & (cfg.route == gpio_pkg::ROUTE_CONTROL);
      SYNTH_REFERENCE_INPUT <= bypass_on & PAD_I
                               & (cfg.route == gpio_pkg::ROUTE_SYNTH);
      SERIAL_LINK_CLOCK_INPUT <= bypass_on & PAD_I
                                 & (cfg.route == gpio_pkg::ROUTE_SERIAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output launch, on launch side clock edges
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      out_q_ff  <= 1'b0;
      lo_out_ff <= 1'b0;
    end else if (dual_out_ok) begin
      if (lau_edges.rise) begin
        out_q_ff <= CORE_OUT[0] ^ cfg.out_inv;
        if (cfg.resync) begin
          lo_out_ff <= CORE_OUT[1] ^ cfg.out_inv;
        end
      end
      if (lau_edges.fall) begin
        if (cfg.resync) begin
          out_q_ff <= lo_out_ff;
        end else begin
          out_q_ff <= CORE_OUT[1] ^ cfg.out_inv;
        end
      end
    end else if (out_edge) begin
      out_q_ff <= CORE_OUT[0] ^ cfg.out_inv;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      oe_q_ff <= 1'b0;
    end else if (oe_edge) begin
      oe_q_ff <= CORE_OE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive
  always_comb begin
    if (cfg.out_reg || dual_out_ok) begin
      nxt_data = out_q_ff;
    end else begin
      nxt_data = CORE_OUT[0];
    end
    if (cfg.oe_reg) begin
      nxt_oe = oe_q_ff;
    end else begin
      nxt_oe = CORE_OE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      PAD_O  <= 1'b0;
      PAD_OE <= 1'b0;
    end else begin
      PAD_OE <= nxt_oe;
      PAD_O  <= nxt_oe & nxt_data;
    end
  end

endmodule

// ===== tb/gpio_io_asserts.sv
`timescale 1ns/1ps
module gpio_io_asserts (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RSTN,
  // Bus handshakes
  input wire logic       AWVALID,
  input wire logic       AWREADY,
  input wire logic       WVALID,
  input wire logic       WREADY,
  input wire logic       BVALID,
  input wire logic       BREADY,
  input wire logic [1:0] BRESP,
  input wire logic       ARVALID,
  input wire logic       ARREADY,
  input wire logic       RVALID,
  input wire logic       RREADY,
  // Pad and bypass
  input wire logic       PAD_I,
  input wire logic       PAD_O,
  input wire logic       PAD_OE,
  input wire logic       BYPASS_INPUT,
  input wire logic       GLOBAL_CLOCK_NET,
  input wire logic       GLOBAL_CONTROL_NET,
  input wire logic       SYNTH_REFERENCE_INPUT,
  input wire logic       SERIAL_LINK_CLOCK_INPUT
);
  default clocking dflt @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_taken;
    ARVALID && ARREADY;
  endsequence
  wr_resp_a: assert property (wr_taken |-> ##[1:3] BVALID)
    else $error("write response missing");
  wr_busy_a: assert property (wr_taken |=> !AWREADY && !WREADY)
    else $error("write ready during pending write");
  rd_resp_a: assert property (rd_taken |-> ##[1:2] RVALID)
    else $error("read response missing");
  rd_busy_a: assert property (rd_taken |=> !ARREADY)
    else $error("read ready during pending read");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  oe_release_a: assert property (!PAD_OE |-> !PAD_O)
    else $error("pad data while released");
  route_single_a: assert property ($onehot0({GLOBAL_CLOCK_NET,
    GLOBAL_CONTROL_NET, SYNTH_REFERENCE_INPUT, SERIAL_LINK_CLOCK_INPUT}))
    else $error("bypass on several nets");
  bypass_pad_a: assert property (BYPASS_INPUT |-> $past(PAD_I))
    else $error("bypass high without pad");
endmodule
bind dual_edge_gpio_io_logic gpio_io_asserts gpio_io_asserts_inst (
  .MCLK, .RSTN, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY,
  .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY, .PAD_I, .PAD_O, .PAD_OE,
  .BYPASS_INPUT, .GLOBAL_CLOCK_NET, .GLOBAL_CONTROL_NET,
  .SYNTH_REFERENCE_INPUT, .SERIAL_LINK_CLOCK_INPUT);

// ===== tb/fabric_model.sv
`timescale 1ns/1ps
module fabric_model (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Bench requests
  input wire logic [1:0] out_req,
  input wire logic       oe_req,
  // Fabric side of the pin
  output logic           launch,
  output logic           capture,
  output logic [1:0]     core_out,
  output logic           core_oe
);
  logic [3:0] cnt_ff;
  ////////////////////////////////////////
  // Core clocks, capture lagging launch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= 4'h0;
      launch  <= 1'h0;
      capture <= 1'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == 4'h7) begin
        launch <= ~launch;
      end
      if (cnt_ff == 4'hA) begin
        capture <= ~capture;
      end
    end
  end
  // Two bits and enable launched at launch rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_out <= 2'h0;
      core_oe  <= 1'h0;
    end else if (cnt_ff == 4'h7 && !launch) begin
      core_out <= out_req;
      core_oe  <= oe_req;
    end
  end
endmodule

// ===== tb/dual_edge_gpio_io_logic_bench.sv
`timescale 1ns/1ps
`include "gpio_map.svh"
module dual_edge_gpio_io_logic_bench;
  logic        mclk = 1'h0;
  logic        rstn = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        ext_pad = 1'h0;
  logic [1:0]  out_req = 2'h0;
  logic        oe_req = 1'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, core_out, core_in, rs, cur, prv;
  logic [31:0] rdata, rv, cv;
  logic        launch, capture, core_oe, bypass, pad_o, pad_oe, pad_i, pv;
  logic [3:0]  nets;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          seed = 7302;
  ////////////////////////////////////////
  always #4 mclk = ~mclk;
  assign pad_i = pad_oe ? pad_o : ext_pad;
  dual_edge_gpio_io_logic dual_edge_gpio_io_logic_inst (
    .MCLK(mclk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .LAUNCH_SIDE_CLOCK(launch), .CAPTURE_SIDE_CLOCK(capture),
    .CORE_OUT(core_out), .CORE_OE(core_oe), .CORE_IN(core_in),
    .BYPASS_INPUT(bypass), .GLOBAL_CLOCK_NET(nets[0]),
    .GLOBAL_CONTROL_NET(nets[1]), .SYNTH_REFERENCE_INPUT(nets[2]),
    .SERIAL_LINK_CLOCK_INPUT(nets[3]), .PAD_I(pad_i), .PAD_O(pad_o),
    .PAD_OE(pad_oe));
  fabric_model fabric_model_inst (.clk(mclk), .rst_n(rstn),
    .out_req(out_req), .oe_req(oe_req), .launch(launch),
    .capture(capture), .core_out(core_out), .core_oe(core_oe));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    while (aw || w) begin
      @(posedge mclk);
      if (aw && awready) begin
        awvalid <= 1'h0;
        aw = 1'h0;
      end
      if (w && wready) begin
        wvalid <= 1'h0;
        w = 1'h0;
      end
    end
    do @(posedge mclk); while (!bvalid);
    bready <= 1'h1;
    @(posedge mclk);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic cfg(input logic [31:0] v);
    logic [1:0] r;
    wr(`CTRL_OFFSET, v, r);
    check("cfg_resp", r, `RESP_OKAY);
  endtask
  task automatic sync(input logic sel, input logic lvl);
    do @(posedge mclk); while ((sel ? capture : launch) !== ~lvl);
    do @(posedge mclk); while ((sel ? capture : launch) !== lvl);
    repeat (8) @(posedge mclk);
  endtask
  function automatic logic pad_exp(input logic inv);
    return oe_req ? out_req[0] ^ inv : ext_pad;
  endfunction
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    rd(`CTRL_OFFSET, rv, rs);
    check("ctrl_reset", rv, 32'h0);
    rd(`STATUS_OFFSET, rv, rs);
    check("status_idle", rv, 32'h0);
    wr(8'h08, 32'hFFFFFFFF, rs);
    check("wr_unmapped", rs, `RESP_SLVERR);
    rd(8'h08, rv, rs);
    check("rd_unmapped", rv, 32'h0);
    check("rd_unmapped_resp", rs, `RESP_SLVERR);
    wr(`STATUS_OFFSET, 32'h3F, rs);
    check("wr_status", rs, `RESP_OKAY);
    cv = $random(seed);
    cfg(cv);
    rd(`CTRL_OFFSET, rv, rs);
    check("ctrl_back", rv, {19'h0, cv[12:0]});
    // Byte strobe: only the second lane lands
    wstrb <= 4'h2;
    cfg(32'h0000FFFF);
    wstrb <= 4'hF;
    rd(`CTRL_OFFSET, rv, rs);
    check("ctrl_strb", rv, {19'h0, 5'h1F, cv[7:0]});
    // Plain pins on every route, then registered and inverted
    for (int i = 0; i < 12; i++) begin
      rv = (i < 8) ? {19'h0, i[1:0], 11'h0} :
           (i < 10) ? 32'h0047 : 32'h007F;
      cfg(rv);
      ext_pad <= 1'($random(seed));
      out_req <= 2'($random(seed));
      oe_req <= 1'($random(seed));
      repeat (110) @(posedge mclk);
      pv = pad_exp(rv[`CTRL_OUT_INV]);
      check("core_in", core_in[0], pv);
      check("pad_oe", pad_oe, oe_req);
      check("pad_o", pad_o, oe_req & pv);
      check("bypass", bypass, pv & ~rv[0]);
      check("route", nets, {3'h0, pv & ~rv[0]} << rv[12:11]);
    end
    // Dual-edge capture, normal then resync
    oe_req <= 1'h0;
    for (int m = 0; m < 2; m++) begin
      cfg({22'h0, m[0], 9'h080});
      rd(`STATUS_OFFSET, rv, rs);
      check("dual_in_on", rv[4], 1'h1);
      for (int k = 0; k < 10; k++) begin
        sync(1'h1, 1'h0);
        if (k > 1) begin
          check("dual_in", core_in, m ? prv : cur);
        end
        prv = cur;
        cur = 2'($random(seed));
        ext_pad <= cur[0];
        sync(1'h1, 1'h1);
        ext_pad <= cur[1];
      end
    end
    cfg(32'h0580);
    rd(`STATUS_OFFSET, rv, rs);
    check("diff_reuse", rv[5:4], 2'h0);
    // Dual-edge launch
    oe_req <= 1'h1;
    for (int k = 0; k < 6; k++) begin
      cfg({22'h0, k[0], 2'h2, k[1], 6'h00});
      out_req <= 2'($random(seed));
      repeat (110) @(posedge mclk);
      sync(1'h0, 1'h1);
      check("dual_rise", pad_o, out_req[0] ^ k[1]);
      sync(1'h0, 1'h0);
      check("dual_fall", pad_o, out_req[1] ^ k[1]);
    end
    summarize();
  end
endmodule
